// ===== hdl/spc_map.svh
// register offsets, field positions, mode codes and timing for the serial port control block
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SPC_OFS_STATUS 3'h0
`define SPC_OFS_CTL1 3'h1
`define SPC_OFS_CTL2 3'h2
`define SPC_OFS_CTL3 3'h3
`define SPC_OFS_DIV 3'h4
`define SPC_OFS_BUF 3'h5
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SPC_ST_STOP 4
`define SPC_ST_START 3
`define SPC_ST_BUSY 2
`define SPC_ST_FULL 0
`define SPC_C1_WCOL 7
`define SPC_C1_OVF 6
`define SPC_C1_EN 5
`define SPC_C1_CKREL 4
`define SPC_MODE_MSB 3
`define SPC_MODE_LSB 0
`define SPC_C2_ACKVAL 5
`define SPC_C2_ACKSEQ 4
`define SPC_C2_RX 3
`define SPC_C2_STOP 2
`define SPC_C2_RESTART 1
`define SPC_C2_START 0
`define SPC_C3_ACK_TIME_STATUS 7
`define SPC_C3_DATA_HOLD_SELECT 3
`define SPC_C3_ADDRESS_HOLD_ENABLE 1
`define SPC_C3_DATA_HOLD_ENABLE 0
`define SPC_ST_WMASK 8'hC0
`define SPC_C2_WMASK 8'hA0
`define SPC_C2_SEQMASK 8'h1F
// ------------------------------------------------------------
// mode codes
// ------------------------------------------------------------
`define SPC_MODE_SPI_SLV_NOSS 4'h5
`define SPC_MODE_SPI_M_BRG 4'hA
`define SPC_MODE_SPI_SLV_SS 4'h4
`define SPC_MODE_I2C_S7 4'h6
`define SPC_MODE_I2C_S10 4'h7
`define SPC_MODE_I2C_MST 4'h8
`define SPC_MODE_I2C_FW 4'hB
`define SPC_MODE_I2C_S7_SP 4'hE
`define SPC_MODE_I2C_S10_SP 4'hF
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SPC_CLK_MHZ 40
`define SPC_HOLD_LONG_NS 300
`define SPC_HOLD_SHORT_NS 100
`define SPC_HOLD_LONG_CYC (((`SPC_HOLD_LONG_NS) * (`SPC_CLK_MHZ) + 999) / 1000)
`define SPC_HOLD_SHORT_CYC (((`SPC_HOLD_SHORT_NS) * (`SPC_CLK_MHZ) + 999) / 1000)
`define SPC_BITS_LAST 3'h7
`endif

// ===== hdl/spc_pkg.sv
// types of the serial port control block
package spc_pkg;
  typedef enum logic [3:0] {
    SPC_IDLE, SPC_START_A, SPC_START_B, SPC_RS_A, SPC_RS_B, SPC_RS_C, SPC_RS_D,
    SPC_STOP_A, SPC_STOP_B, SPC_STOP_C, SPC_ACK_HOLD, SPC_ACK_SET, SPC_ACK_HI,
    SPC_ACK_LO, SPC_RX_LO, SPC_RX_HI
  } spc_seq_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic [7:0] div;
    logic [7:0] buffer;
    logic [7:0] rdata;
    spc_seq_t st;
    logic [8:0] brg;
    logic [3:0] hold;
    logic [2:0] bits;
    logic [7:0] shift;
    logic scl_oe;
    logic sda_oe;
    logic spi_own;
    logic i2c_own;
    logic scl_hold;
  } spc_state_t;
endpackage

// ===== hdl/spc_port_ctl.sv
// control and status registers with the master sequencer of the serial port
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_port_ctl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // i2c lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  // slave shifter events
  input wire logic slv_byte_fall8,
  input wire logic slv_byte_is_addr,
  input wire logic slv_addr_match,
  input wire logic slv_ninth_rise,
  input wire logic spi_rx_done,
  // pin ownership and clock stretch
  output logic spi_pins_own,
  output logic i2c_pins_own,
  output logic slv_scl_hold
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic srst_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign srst_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_spi(input logic [3:0] m);
    is_spi = (m <= `SPC_MODE_SPI_SLV_NOSS) || (m == `SPC_MODE_SPI_M_BRG);
  endfunction
  function automatic logic is_spi_master(input logic [3:0] m);
    is_spi_master = (m < `SPC_MODE_SPI_SLV_SS) || (m == `SPC_MODE_SPI_M_BRG);
  endfunction
  function automatic logic is_i2c_slave(input logic [3:0] m);
    is_i2c_slave = (m == `SPC_MODE_I2C_S7) || (m == `SPC_MODE_I2C_S10) ||
                   (m == `SPC_MODE_I2C_S7_SP) || (m == `SPC_MODE_I2C_S10_SP);
  endfunction
  function automatic logic is_i2c(input logic [3:0] m);
    is_i2c = is_i2c_slave(m) || (m == `SPC_MODE_I2C_MST) || (m == `SPC_MODE_I2C_FW);
  endfunction
  function automatic logic [3:0] hold_cycles(input logic long_hold);
    hold_cycles = long_hold ? 4'(`SPC_HOLD_LONG_CYC) : 4'(`SPC_HOLD_SHORT_CYC);
  endfunction
  // half period of (div+1)*2 clocks, counted down to zero
  function automatic logic [8:0] brg_reload(input logic [7:0] d);
    brg_reload = {d, 1'b1};
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  spc_pkg::spc_state_t q, n;
  logic [3:0] mode;
  logic [3:0] hold_n;
  logic en, mst, slv, idle, tick, hold_done;
  always_comb begin
    n = q;
    mode = q.ctl1[`SPC_MODE_MSB:`SPC_MODE_LSB];
    en = q.ctl1[`SPC_C1_EN];
    mst = en && (mode == `SPC_MODE_I2C_MST);
    slv = en && is_i2c_slave(mode);
    idle = (q.st == spc_pkg::SPC_IDLE);
    hold_n = hold_cycles(q.ctl3[`SPC_C3_DATA_HOLD_SELECT]);
    tick = 1'b0;
    n.rdata = 8'h00;
    // bus reads
    if (reg_rd) begin
      if (reg_addr == `SPC_OFS_STATUS) begin
        n.rdata = q.status;
      end else if (reg_addr == `SPC_OFS_CTL1) begin
        n.rdata = q.ctl1;
      end else if (reg_addr == `SPC_OFS_CTL2) begin
        n.rdata = q.ctl2;
      end else if (reg_addr == `SPC_OFS_CTL3) begin
        n.rdata = q.ctl3;
        n.rdata[`SPC_C3_ACK_TIME_STATUS] = q.ctl3[`SPC_C3_ACK_TIME_STATUS] &
                                  (q.ctl3[`SPC_C3_ADDRESS_HOLD_ENABLE] | q.ctl3[`SPC_C3_DATA_HOLD_ENABLE]);
      end else if (reg_addr == `SPC_OFS_DIV) begin
        n.rdata = q.div;
      end else if (reg_addr == `SPC_OFS_BUF) begin
        n.rdata = q.buffer;
        n.status[`SPC_ST_FULL] = 1'b0;
      end
    end
    // bus writes
    if (reg_wr) begin
      if (reg_addr == `SPC_OFS_STATUS) begin
        n.status = (q.status & ~`SPC_ST_WMASK) | (reg_wdata & `SPC_ST_WMASK);
      end else if (reg_addr == `SPC_OFS_CTL1) begin
        n.ctl1 = reg_wdata;
        n.ctl1[`SPC_C1_WCOL] = q.ctl1[`SPC_C1_WCOL] & reg_wdata[`SPC_C1_WCOL];
        n.ctl1[`SPC_C1_OVF] = q.ctl1[`SPC_C1_OVF] & reg_wdata[`SPC_C1_OVF];
      end else if (reg_addr == `SPC_OFS_CTL2) begin
        n.ctl2 = (q.ctl2 & ~`SPC_C2_WMASK) | (reg_wdata & `SPC_C2_WMASK);
        if (idle && mst) begin
          n.brg = brg_reload(q.div);
          n.hold = hold_n;
          if (reg_wdata[`SPC_C2_START]) begin
            n.ctl2[`SPC_C2_START] = 1'b1;
            n.st = spc_pkg::SPC_START_A;
          end else if (reg_wdata[`SPC_C2_RESTART]) begin
            n.ctl2[`SPC_C2_RESTART] = 1'b1;
            n.st = spc_pkg::SPC_RS_A;
          end else if (reg_wdata[`SPC_C2_STOP]) begin
            n.ctl2[`SPC_C2_STOP] = 1'b1;
            n.st = spc_pkg::SPC_STOP_A;
          end else if (reg_wdata[`SPC_C2_RX]) begin
            n.ctl2[`SPC_C2_RX] = 1'b1;
            n.bits = 3'h0;
            n.st = spc_pkg::SPC_RX_LO;
          end else if (reg_wdata[`SPC_C2_ACKSEQ]) begin
            n.ctl2[`SPC_C2_ACKSEQ] = 1'b1;
            n.st = spc_pkg::SPC_ACK_HOLD;
          end
        end
      end else if (reg_addr == `SPC_OFS_CTL3) begin
        n.ctl3 = reg_wdata;
        // ack-time status belongs to hardware, software cannot write it
        n.ctl3[`SPC_C3_ACK_TIME_STATUS] = q.ctl3[`SPC_C3_ACK_TIME_STATUS];
      end else if (reg_addr == `SPC_OFS_DIV) begin
        n.div = reg_wdata;
      end else if (reg_addr == `SPC_OFS_BUF) begin
        if (!idle) begin
          n.ctl1[`SPC_C1_WCOL] = 1'b1;
        end else begin
          n.buffer = reg_wdata;
        end
      end
    end
    // baud counter, reloaded each cycle while a released clock is held low by another party
    if (!idle) begin
      if (!q.scl_oe && !scl_i) begin
        n.brg = brg_reload(q.div);
      end else if (q.brg == 9'h000) begin
        tick = 1'b1;
        n.brg = brg_reload(q.div);
      end else begin
        n.brg = q.brg - 9'h001;
      end
    end
    hold_done = (q.hold == 4'h0);
    if (!hold_done) begin
      n.hold = q.hold - 4'h1;
    end
    // master sequencer
    case (q.st)
      spc_pkg::SPC_START_A: if (tick) begin
        n.sda_oe = 1'b1;
        n.st = spc_pkg::SPC_START_B;
      end
      spc_pkg::SPC_START_B: if (tick) begin
        n.scl_oe = 1'b1;
        n.ctl2[`SPC_C2_START] = 1'b0;
        n.status[`SPC_ST_START] = 1'b1;
        n.status[`SPC_ST_STOP] = 1'b0;
        n.st = spc_pkg::SPC_IDLE;
      end
      spc_pkg::SPC_RS_A: if (hold_done) begin
        n.sda_oe = 1'b0;
        n.brg = brg_reload(q.div);
        n.st = spc_pkg::SPC_RS_B;
      end
      spc_pkg::SPC_RS_B: if (tick) begin
        n.scl_oe = 1'b0;
        n.st = spc_pkg::SPC_RS_C;
      end
      spc_pkg::SPC_RS_C: if (tick) begin
        n.sda_oe = 1'b1;
        n.st = spc_pkg::SPC_RS_D;
      end
      spc_pkg::SPC_RS_D: if (tick) begin
        n.scl_oe = 1'b1;
        n.ctl2[`SPC_C2_RESTART] = 1'b0;
        n.status[`SPC_ST_START] = 1'b1;
        n.st = spc_pkg::SPC_IDLE;
      end
      spc_pkg::SPC_STOP_A: if (hold_done) begin
        n.sda_oe = 1'b1;
        n.brg = brg_reload(q.div);
        n.st = spc_pkg::SPC_STOP_B;
      end
      spc_pkg::SPC_STOP_B: if (tick) begin
        n.scl_oe = 1'b0;
        n.st = spc_pkg::SPC_STOP_C;
      end
      spc_pkg::SPC_STOP_C: if (tick) begin
        n.sda_oe = 1'b0;
        n.ctl2[`SPC_C2_STOP] = 1'b0;
        n.status[`SPC_ST_STOP] = 1'b1;
        n.status[`SPC_ST_START] = 1'b0;
        n.st = spc_pkg::SPC_IDLE;
      end
      spc_pkg::SPC_ACK_HOLD: if (hold_done) begin
        n.sda_oe = ~q.ctl2[`SPC_C2_ACKVAL];
        n.brg = brg_reload(q.div);
        n.st = spc_pkg::SPC_ACK_SET;
      end
      spc_pkg::SPC_ACK_SET: if (tick) begin
        n.scl_oe = 1'b0;
        n.st = spc_pkg::SPC_ACK_HI;
      end
      spc_pkg::SPC_ACK_HI: if (tick) begin
        n.scl_oe = 1'b1;
        n.hold = hold_n;
        n.st = spc_pkg::SPC_ACK_LO;
      end
      spc_pkg::SPC_ACK_LO: if (hold_done) begin
        n.sda_oe = 1'b0;
        n.ctl2[`SPC_C2_ACKSEQ] = 1'b0;
        n.st = spc_pkg::SPC_IDLE;
      end
      spc_pkg::SPC_RX_LO: if (tick) begin
        // let sda go so the far slave can drive the bit
        n.sda_oe = 1'b0;
        n.scl_oe = 1'b0;
        n.st = spc_pkg::SPC_RX_HI;
      end
      spc_pkg::SPC_RX_HI: if (tick) begin
        n.shift = {q.shift[6:0], sda_i};
        n.scl_oe = 1'b1;
        n.bits = q.bits + 3'h1;
        n.st = spc_pkg::SPC_RX_LO;
        if (q.bits == `SPC_BITS_LAST) begin
          n.buffer = {q.shift[6:0], sda_i};
          if (q.status[`SPC_ST_FULL]) begin
            n.ctl1[`SPC_C1_OVF] = 1'b1;
          end
          n.status[`SPC_ST_FULL] = 1'b1;
          n.ctl2[`SPC_C2_RX] = 1'b0;
          n.st = spc_pkg::SPC_IDLE;
        end
      end
      default: begin
      end
    endcase
    // slave holding and acknowledge time
    if (slv_ninth_rise) begin
      n.ctl3[`SPC_C3_ACK_TIME_STATUS] = 1'b0;
    end
    if (slv && slv_byte_fall8 && (!slv_byte_is_addr || slv_addr_match)) begin
      if (slv_byte_is_addr ? q.ctl3[`SPC_C3_ADDRESS_HOLD_ENABLE] : q.ctl3[`SPC_C3_DATA_HOLD_ENABLE]) begin
        n.ctl1[`SPC_C1_CKREL] = 1'b0;
      end
      if (q.ctl3[`SPC_C3_ADDRESS_HOLD_ENABLE] || q.ctl3[`SPC_C3_DATA_HOLD_ENABLE]) begin
        n.ctl3[`SPC_C3_ACK_TIME_STATUS] = 1'b1;
      end
    end
    // spi receive completion
    if (spi_rx_done && en && is_spi(mode)) begin
      if (q.status[`SPC_ST_FULL] && !is_spi_master(mode)) begin
        n.ctl1[`SPC_C1_OVF] = 1'b1;
      end
      n.status[`SPC_ST_FULL] = 1'b1;
    end
    // port off: sequencer and line state drop back to idle
    if (!n.ctl1[`SPC_C1_EN]) begin
      n.st = spc_pkg::SPC_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.status[`SPC_ST_START] = 1'b0;
      n.status[`SPC_ST_STOP] = 1'b0;
      n.ctl2 = n.ctl2 & ~`SPC_C2_SEQMASK;
    end
    n.status[`SPC_ST_BUSY] = (n.st != spc_pkg::SPC_IDLE);
    n.spi_own = n.ctl1[`SPC_C1_EN] && is_spi(n.ctl1[`SPC_MODE_MSB:`SPC_MODE_LSB]);
    n.i2c_own = n.ctl1[`SPC_C1_EN] && is_i2c(n.ctl1[`SPC_MODE_MSB:`SPC_MODE_LSB]);
    n.scl_hold = n.ctl1[`SPC_C1_EN] && is_i2c_slave(n.ctl1[`SPC_MODE_MSB:`SPC_MODE_LSB]) &&
                 !n.ctl1[`SPC_C1_CKREL];
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign spi_pins_own = q.spi_own;
  assign i2c_pins_own = q.i2c_own;
  assign slv_scl_hold = q.scl_hold;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [4:0] low_cnt_q;
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      low_cnt_q <= 5'h00;
    end else if (!q.scl_oe) begin
      low_cnt_q <= 5'h00;
    end else if (low_cnt_q != 5'h1F) begin
      low_cnt_q <= low_cnt_q + 5'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!srst_n);
  sequence s_ctl1_wr(logic [7:0] v);
    reg_wr && reg_addr == `SPC_OFS_CTL1 && reg_wdata == v;
  endsequence
  property p_spi_own;
    s_ctl1_wr(8'h20) |=> spi_pins_own && !i2c_pins_own;
  endproperty
  a_spi_own: assert property (p_spi_own) else $error("spi pins not taken");
  property p_i2c_own;
    s_ctl1_wr(8'h28) |=> i2c_pins_own && !spi_pins_own;
  endproperty
  a_i2c_own: assert property (p_i2c_own) else $error("i2c pins not taken");
  property p_rsv_mode;
    (s_ctl1_wr(8'h29) or s_ctl1_wr(8'h2C) or s_ctl1_wr(8'h2D)) |=> !spi_pins_own && !i2c_pins_own;
  endproperty
  a_rsv_mode: assert property (p_rsv_mode) else $error("reserved mode owns pins");
  property p_spi_mst_ovf;
    q.spi_own && is_spi_master(mode) && !q.ctl1[`SPC_C1_OVF] |=> !q.ctl1[`SPC_C1_OVF];
  endproperty
  a_spi_mst_ovf: assert property (p_spi_mst_ovf) else $error("overflow in spi master");
  sequence s_ack_end;
    q.st == spc_pkg::SPC_ACK_LO && hold_done && q.ctl1[`SPC_C1_EN];
  endsequence
  property p_ack_clear;
    s_ack_end |=> !q.ctl2[`SPC_C2_ACKSEQ] && !sda_oe && idle;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack bit not cleared");
  property p_ack_value;
    q.st == spc_pkg::SPC_ACK_HI |-> sda_oe == !q.ctl2[`SPC_C2_ACKVAL];
  endproperty
  a_ack_value: assert property (p_ack_value) else $error("wrong ack level");
  property p_busy_ignore;
    !idle && reg_wr && reg_addr == `SPC_OFS_CTL2 |=>
      ((q.ctl2 & ~$past(q.ctl2)) & `SPC_C2_SEQMASK) == 8'h00;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("request taken while busy");
  property p_sda_hold;
    q.scl_oe && $past(q.scl_oe) && $changed(sda_oe) |-> low_cnt_q >= 5'(hold_cycles(q.ctl3[`SPC_C3_DATA_HOLD_SELECT]));
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda hold too short");
  property p_addr_hold;
    slv && q.ctl3[`SPC_C3_ADDRESS_HOLD_ENABLE] && slv_byte_fall8 && slv_byte_is_addr && slv_addr_match &&
      !(reg_wr && reg_addr == `SPC_OFS_CTL1) |=> !q.ctl1[`SPC_C1_CKREL] && slv_scl_hold;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address hold missed");
endmodule

// ===== bench/spc_bus_far.sv
// far side of the serial port: pulled-up i2c lines and a slave that sends one byte
`timescale 1ns/1ps
module spc_bus_far (
  // clock
  input wire logic mclk,
  // pull-down enables from the port
  input wire logic scl_oe,
  input wire logic sda_oe,
  // bench control
  input wire logic stretch,
  input wire logic send_en,
  input wire logic [7:0] send_byte,
  // resolved line levels
  output logic scl_line,
  output logic sda_line
);
  logic [3:0] cnt_q = 4'h0;
  logic scl_prev_q = 1'b1;
  logic bit_low;

  // ----------------------------------------
  // open-drain lines
  // ----------------------------------------
  // a line is low while the port or the far side pulls it down; released lines float to the pull-up level
  assign bit_low = send_en && (cnt_q < 4'h8) && !send_byte[3'h7 - cnt_q[2:0]];
  assign scl_line = !(scl_oe || stretch);
  assign sda_line = !(sda_oe || bit_low);

  // ----------------------------------------
  // byte sender
  // ----------------------------------------
  // msb first, next bit after each falling scl, then the line is let go
  always @(posedge mclk) begin
    scl_prev_q <= scl_line;
    if (!send_en) begin
      cnt_q <= 4'h0;
    end else if (scl_prev_q && !scl_line && cnt_q < 4'h8) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// ===== bench/sync_serial_port_control_bench.sv
// self-checking bench of the serial port control block
`timescale 1ns/1ps
`include "spc_map.svh"
module sync_serial_port_control_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_line, sda_line, scl_o, scl_oe, sda_o, sda_oe;
  logic spi_pins_own, i2c_pins_own, slv_scl_hold;
  logic [4:0] ev = 5'h00;
  logic stretch = 1'b0;
  logic send_en = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t_sda_up, t_scl_up, t_scl_dn, t_w;
  int dur [2];
  logic sda_p = 1'b0;
  logic scl_p = 1'b0;
  logic sda_rel;
  logic [7:0] s3 [3] = '{8'h02, 8'h01, 8'h00};
  logic [4:0] sev [3] = '{5'h07, 5'h01, 5'h01};

  always #12.5 mclk = ~mclk;

  spc_port_ctl DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_line), .sda_i(sda_line), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .slv_byte_fall8(ev[0]), .slv_byte_is_addr(ev[1]),
    .slv_addr_match(ev[2]), .slv_ninth_rise(ev[3]), .spi_rx_done(ev[4]), .spi_pins_own(spi_pins_own),
    .i2c_pins_own(i2c_pins_own), .slv_scl_hold(slv_scl_hold)
  );

  spc_bus_far far (
    .mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(stretch), .send_en(send_en),
    .send_byte(8'hA5), .scl_line(scl_line), .sda_line(sda_line)
  );

  // ----------------------------------------
  // line event monitor
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (reg_wr && reg_addr == 3'h2) t_w = cyc;
    if (sda_oe && !sda_p) t_sda_up = cyc;
    if (scl_oe && !scl_p) t_scl_up = cyc;
    if (!scl_oe && scl_p) begin
      t_scl_dn = cyc;
      sda_rel = sda_oe;
    end
    sda_p = sda_oe;
    scl_p = scl_oe;
  end

  // ----------------------------------------
  // access and check tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask

  task automatic cr(input string n, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, e, d & m);
  endtask

  task automatic pulse(input logic [4:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 5'h00;
  endtask

  task automatic wait_idle;
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'hFF;
    while ((d & 8'h1F) !== 8'h00 && n < 300) begin
      rd(3'h2, d);
      n++;
    end
    chk("sequence bits", 8'h00, d & 8'h1F);
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    give_verdict();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 8; a++) cr("reset value", 3'(a), 8'hFF, 8'h00);
    wr(3'h0, 8'hFF);
    cr("status read-only", 3'h0, 8'hFF, 8'hC0);
    wr(3'h0, 8'h00);
    $display("test reset done");
    wr(3'h4, 8'h03);
    for (int m = 0; m < 16; m++) begin
      wr(3'h1, 8'h20 | 8'(m));
      repeat (3) @(posedge mclk);
      chk("spi own", {7'h0, (m <= 5 || m == 10)}, {7'h0, spi_pins_own});
      chk("i2c own", {7'h0, (m inside {6, 7, 8, 11, 14, 15})}, {7'h0, i2c_pins_own});
      cr("mode field", 3'h1, 8'hFF, 8'h20 | 8'(m));
    end
    wr(3'h1, 8'h08);
    repeat (3) @(posedge mclk);
    chk("own off", 8'h00, {6'h0, spi_pins_own, i2c_pins_own});
    $display("test modes done");
    for (int k = 0; k < 2; k++) begin
      wr(3'h4, 8'(3 + 2 * k));
      wr(3'h1, 8'h28);
      wr(3'h2, 8'h01);
      if (k == 0) begin
        wr(3'h2, 8'h04);
        wr(3'h5, 8'h5A);
      end
      wait_idle();
      chk("start span", 8'(8 + 4 * k), 8'(t_scl_up - t_sda_up));
      cr("start seen", 3'h0, k == 0 ? 8'h18 : 8'h08, 8'h08);
      chk("scl held", 8'h01, {7'h0, scl_oe});
      if (k == 0) begin
        cr("write clash", 3'h1, 8'h80, 8'h80);
        wr(3'h1, 8'h28);
        cr("clash cleared", 3'h1, 8'hFF, 8'h28);
        @(posedge mclk);
        send_en <= 1'b1;
        stretch <= 1'b1;
        wr(3'h2, 8'h08);
        repeat (10) @(posedge mclk);
        stretch <= 1'b0;
        wait_idle();
        cr("rx full", 3'h0, 8'h01, 8'h01);
        cr("rx byte", 3'h5, 8'hFF, 8'hA5);
        cr("full cleared", 3'h0, 8'h01, 8'h00);
        send_en <= 1'b0;
        for (int i = 0; i < 2; i++) begin
          wr(3'h3, 8'(i << 3));
          wr(3'h2, i == 0 ? 8'h30 : 8'h10);
          wait_idle();
          chk("ack level", 8'(i), {7'h0, sda_rel});
          dur[i] = t_scl_dn - t_w;
        end
        chk("hold span", 8'(`SPC_HOLD_LONG_CYC - `SPC_HOLD_SHORT_CYC), 8'(dur[1] - dur[0]));
      end else begin
        wr(3'h2, 8'h02);
        wait_idle();
        chk("restart lines", 8'h03, {6'h0, scl_oe, sda_oe});
      end
      wr(3'h2, 8'h04);
      wait_idle();
      cr("stop seen", 3'h0, 8'h10, 8'h10);
      chk("lines free", 8'h00, {6'h0, scl_oe, sda_oe});
    end
    $display("test master done");
    wr(3'h1, 8'h20);
    pulse(5'h10);
    pulse(5'h10);
    cr("master overflow", 3'h1, 8'h40, 8'h00);
    wr(3'h1, 8'h24);
    pulse(5'h10);
    pulse(5'h10);
    cr("slave overflow", 3'h1, 8'h40, 8'h40);
    wr(3'h1, 8'h24);
    cr("overflow cleared", 3'h1, 8'h40, 8'h00);
    $display("test spi done");
    for (int i = 0; i < 3; i++) begin
      wr(3'h1, 8'h36);
      wr(3'h3, s3[i]);
      pulse(sev[i]);
      repeat (2) @(posedge mclk);
      cr("clock release", 3'h1, 8'h10, i == 2 ? 8'h10 : 8'h00);
      chk("scl hold", i == 2 ? 8'h00 : 8'h01, {7'h0, slv_scl_hold});
      cr("ack time", 3'h3, 8'h80, i == 2 ? 8'h00 : 8'h80);
      if (i == 1) begin
        wr(3'h3, 8'h00);
        cr("ack time gated", 3'h3, 8'h80, 8'h00);
        wr(3'h3, 8'h01);
        cr("ack time kept", 3'h3, 8'h80, 8'h80);
      end
      pulse(5'h08);
      cr("ack time end", 3'h3, 8'h80, 8'h00);
    end
    $display("test slave done");
    give_verdict();
  end
endmodule
